// File: design/dpw_pot_ctrl.sv
/*
  Two-wire serial slave front end and wiper/terminal control of a volatile
  digital potentiometer, with an APB register port.
  Assumes an external bus master drives SCL; pins are asynchronous to pclk;
  presetn stands for the supply fault reset.
*/
// The APB slave port and the register addresses were decided locally.
// What this block does
// - supply fault reset loads each wiper with mid scale
// - terminal register holds a, b and wiper connect per network
// - shutdown bit low disconnects a and ties wiper to b
// - serial interface keeps working and executing during shutdown
// - shutdown overrides connect bits without altering their stored values
// - leaving shutdown restores wiper code and connect-bit control
// - each network shuts down independently by its own bits
// - slave only; never drives the serial clock
// - data level captured at each rising serial clock edge
// - data change while clock high is a start or stop
// - works at standard, fast and high-speed clock rates
// - never holds the clock low; read data always ready
// - address pin 0 captured at reset and used afterwards
// - only 7-bit addressing; 10-bit transfers not recognised
// - data falling while clock high starts a transfer
// - acknowledge by driving data low after a matching address and after each received byte
// - stop returns the serial logic to idle
`timescale 1ns/100ps
`include "dpw_cfg.svh"

module dpw_pot_ctrl
  import dpw_pkg::*;
#(
  parameter int RES_BITS = 8,
  parameter int NUM_NET  = 2
)
(
  // clock and reset
  input  wire logic      pclk,
  input  wire logic      presetn,
  // apb slave
  input  wire logic      psel,
  input  wire logic      penable,
  input  wire logic      pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]    prdata,
  output logic           pready,
  output logic           pslverr,
  // serial pins
  input  wire logic      scl_in,
  input  wire logic      sda_in,
  output logic           sda_out,
  output logic           sda_oe_n,
  // address pins
  input  wire logic      addr_pin_0,
  input  wire logic      addr_pin_1,
  input  wire logic      addr_pin_2,
  // resistor networks
  output dpw_net_out_type [NUM_NET-1:0] net_out
);

  localparam logic [9:0] FULL = 10'(1 << RES_BITS);
  localparam logic [9:0] MID  = (RES_BITS == 8) ? `DPW_WIPER_MID_8BIT
                                                : `DPW_WIPER_MID_7BIT;

  if (!(RES_BITS == 7 || RES_BITS == 8))
    $error("RES_BITS must be 7 or 8");
  if (NUM_NET < 1 || NUM_NET > 2)
    $error("NUM_NET must be 1 or 2");
  // high-speed half period must outlast the sync delay
  if (`DPW_HS_SCL_CYCLES / 2 <= `DPW_SYNC_LATENCY)
    $error("pclk too slow for high-speed serial clock");

  // ========================================================================
  // pin synchronisers
  logic [1:0] pin_s1_q;
  logic [1:0] pin_s2_q;
  logic [1:0] pin_s3_q;
  logic [2:0] adr_s1_q;
  logic [2:0] adr_s2_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_s1_q <= 2'h3;
      pin_s2_q <= 2'h3;
      pin_s3_q <= 2'h3;
      adr_s1_q <= 3'h7;
      adr_s2_q <= 3'h7;
    end
    else
    begin
      pin_s1_q <= {scl_in, sda_in};
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      adr_s1_q <= {addr_pin_2, addr_pin_1, addr_pin_0};
      adr_s2_q <= adr_s1_q;
    end
  end

  logic scl_s;
  logic sda_s;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;

  assign scl_s     = pin_s2_q[1];
  assign sda_s     = pin_s2_q[0];
  assign scl_rise  = scl_s & ~pin_s3_q[1];
  assign scl_fall  = ~scl_s & pin_s3_q[1];
  assign start_det = scl_s & pin_s3_q[1] & pin_s3_q[0] & ~sda_s;
  assign stop_det  = scl_s & pin_s3_q[1] & ~pin_s3_q[0] & sda_s;

  // ========================================================================
  // address pin 0 capture after reset release
  logic [1:0] cap_cnt_q;
  logic       a0_lat_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cap_cnt_q <= 2'h0;
      a0_lat_q  <= 1'b0;
    end
    else if (cap_cnt_q != `DPW_A0_CAPTURE)
    begin
      // wait until the synchroniser carries the post-reset pin level
      cap_cnt_q <= cap_cnt_q + 2'h1;
      if (cap_cnt_q + 2'h1 == `DPW_A0_CAPTURE)
        a0_lat_q <= adr_s2_q[0];
    end
  end

  // ========================================================================
  // serial slave state machine
  // pins 1 and 2 are read live; the board keeps them static
  dpw_i2c_state_type state_q;
  logic [3:0]        bit_cnt_q;
  logic [7:0]        shift_q;
  logic              rw_q;
  logic              drv_low_q;
  logic [7:0]        rx_last_q;
  logic [7:0]        rx_count_q;
  logic [6:0]        my_addr;

  assign my_addr = {`DPW_DEV_CODE, adr_s2_q[2:1], a0_lat_q};

  // shutdown has no path into this process, so frames always run
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q    <= ST_IDLE;
      bit_cnt_q  <= 4'h0;
      shift_q    <= 8'h00;
      rw_q       <= 1'b0;
      drv_low_q  <= 1'b0;
      rx_last_q  <= 8'h00;
      rx_count_q <= 8'h00;
    end
    else if (start_det)
    begin
      state_q   <= ST_ADDR;
      bit_cnt_q <= 4'h0;
      drv_low_q <= 1'b0;
    end
    else if (stop_det)
    begin
      state_q   <= ST_IDLE;
      drv_low_q <= 1'b0;
    end
    else
    begin
      unique case (state_q)
        ST_IDLE:
        begin
        end
        ST_ADDR, ST_RX:
        begin
          if (scl_rise)
          begin
            shift_q   <= {shift_q[6:0], sda_s};
            bit_cnt_q <= bit_cnt_q + 4'h1;
          end
          else if (scl_fall && bit_cnt_q == 4'h8)
          begin
            bit_cnt_q <= 4'h0;
            if (state_q == ST_RX)
            begin
              rx_last_q  <= shift_q;
              rx_count_q <= rx_count_q + 8'h01;
              drv_low_q  <= 1'b1;
              state_q    <= ST_RX_ACK;
            end
            // 10-bit headers never match the fixed code
            else if (shift_q[7:1] == my_addr)
            begin
              rw_q      <= shift_q[0];
              drv_low_q <= 1'b1;
              state_q   <= ST_ADDR_ACK;
            end
            else
              state_q <= ST_IDLE;
          end
        end
        ST_ADDR_ACK:
        begin
          if (scl_fall)
          begin
            bit_cnt_q <= 4'h0;
            if (rw_q)
            begin
              // byte is ready at once, so no clock stretching
              shift_q   <= rx_last_q;
              drv_low_q <= ~rx_last_q[7];
              state_q   <= ST_TX;
            end
            else
            begin
              drv_low_q <= 1'b0;
              state_q   <= ST_RX;
            end
          end
        end
        ST_RX_ACK:
        begin
          if (scl_fall)
          begin
            drv_low_q <= 1'b0;
            state_q   <= ST_RX;
          end
        end
        ST_TX:
        begin
          if (scl_fall)
          begin
            bit_cnt_q <= bit_cnt_q + 4'h1;
            if (bit_cnt_q == 4'h7)
            begin
              drv_low_q <= 1'b0;
              state_q   <= ST_TX_ACK;
            end
            else
            begin
              shift_q   <= {shift_q[6:0], 1'b0};
              drv_low_q <= ~shift_q[6];
            end
          end
        end
        ST_TX_ACK:
        begin
          if (scl_rise && sda_s)
            state_q <= ST_IDLE;
          else if (scl_fall)
          begin
            bit_cnt_q <= 4'h0;
            shift_q   <= rx_last_q;
            drv_low_q <= ~rx_last_q[7];
            state_q   <= ST_TX;
          end
        end
      endcase
    end
  end

  // ========================================================================
  // open-drain data pin; no clock driver exists at all
  logic sda_oe_n_q;
  logic sda_out_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sda_oe_n_q <= 1'b1;
      sda_out_q  <= 1'b0;
    end
    else
    begin
      sda_oe_n_q <= ~drv_low_q;
      sda_out_q  <= 1'b0;
    end
  end

  assign sda_oe_n = sda_oe_n_q;
  assign sda_out  = sda_out_q;

  // ========================================================================
  // apb slave: answers in the first access cycle
  logic        pready_q;
  logic [31:0] prdata_q;
  logic        pslverr_q;
  logic [31:0] rd_d;
  logic        err_d;
  logic        apb_wr;
  logic        cmd_wr;
  logic [7:0]  terminal_connect_reg_q;
  logic [9:0]  wiper_q [NUM_NET];

  assign apb_wr = psel & penable & pready_q & pwrite;
  assign cmd_wr = apb_wr & (paddr == `DPW_OFS_CMD);

  always_comb
  begin
    rd_d  = 32'h0000_0000;
    err_d = 1'b0;
    if (paddr == `DPW_OFS_TERMINAL_CONNECT_REG)
      rd_d = {24'h00_0000, terminal_connect_reg_q};
    else if (paddr == `DPW_OFS_CMD)
      rd_d = 32'h0000_0000;
    else if (paddr == `DPW_OFS_STATUS)
    begin
      rd_d[`DPW_STAT_A0_POS]   = a0_lat_q;
      rd_d[`DPW_STAT_BUSY_POS] = (state_q != ST_IDLE);
      rd_d[`DPW_STAT_LAST_LSB +: 8] = rx_last_q;
      rd_d[`DPW_STAT_CNT_LSB +: 8]  = rx_count_q;
    end
    else
    begin
      err_d = 1'b1;
      for (int n = 0; n < NUM_NET; n++)
      begin
        if (paddr == 8'(`DPW_OFS_WIPER0 + 4 * n))
        begin
          rd_d  = {22'h00_0000, wiper_q[n]};
          err_d = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_q  <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end
    else
    begin
      pready_q  <= psel & ~penable;
      prdata_q  <= rd_d;
      pslverr_q <= psel & ~penable & err_d;
    end
  end

  assign pready  = pready_q;
  assign prdata  = prdata_q;
  assign pslverr = pslverr_q;

  // ========================================================================
  // terminal control register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      terminal_connect_reg_q <= `DPW_TERMINAL_CONNECT_REG_RESET;
    else if (apb_wr && paddr == `DPW_OFS_TERMINAL_CONNECT_REG)
      terminal_connect_reg_q <= pwdata[7:0];
  end

  // ========================================================================
  // per-network wiper registers and network control
  for (genvar i = 0; i < NUM_NET; i++)
  begin : g_net
    localparam logic [7:0] OFS = 8'(`DPW_OFS_WIPER0 + 4 * i);
    logic inc;
    logic dec;

    // both bits at once cancel out
    assign inc = pwdata[2*i + `DPW_CMD_INC_POS]
               & ~pwdata[2*i + `DPW_CMD_DEC_POS];
    assign dec = pwdata[2*i + `DPW_CMD_DEC_POS]
               & ~pwdata[2*i + `DPW_CMD_INC_POS];

    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
        wiper_q[i] <= MID;
      else if (apb_wr && paddr == OFS)
        wiper_q[i] <= pwdata[9:0];
      else if (cmd_wr && inc && wiper_q[i] < FULL)
        wiper_q[i] <= wiper_q[i] + 10'h001;
      else if (cmd_wr && dec && wiper_q[i] != 10'h000
               && wiper_q[i] <= FULL)
        wiper_q[i] <= wiper_q[i] - 10'h001;
    end

    dpw_net_ctrl #(
      .RES_BITS (RES_BITS)
    ) u_net (
      .pclk       (pclk),
      .presetn    (presetn),
      .wiper_code (wiper_q[i]),
      .terminal_connect_reg       (terminal_connect_reg_q[`DPW_TERMINAL_CONNECT_REG_NET_BITS*i +: `DPW_TERMINAL_CONNECT_REG_NET_BITS]),
      .net_out    (net_out[i])
    );
  end

  // ========================================================================
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_cmd0(logic want_inc);
    cmd_wr && pwdata[1:0] == (want_inc ? 2'b01 : 2'b10);
  endsequence

  chk_zero_dec_ignored: assert property (
    s_cmd0(1'b0) and (wiper_q[0] == 10'h000) |=> wiper_q[0] == 10'h000)
    else $error("decrement at zero changed the wiper");

  chk_full_inc_ignored: assert property (
    s_cmd0(1'b1) and (wiper_q[0] == FULL) |=> wiper_q[0] == FULL)
    else $error("increment at full scale changed the wiper");

  chk_over_full_hold: assert property (
    cmd_wr && wiper_q[0] > FULL |=> $stable(wiper_q[0]))
    else $error("step above full scale changed the wiper");

  chk_terminal_connect_reg_kept: assert property (
    !(apb_wr && paddr == `DPW_OFS_TERMINAL_CONNECT_REG) |=> $stable(terminal_connect_reg_q))
    else $error("terminal settings changed without a write");

  sequence s_start;
    start_det ##1 (state_q == ST_ADDR);
  endsequence

  chk_start_detect: assert property (
    start_det |-> s_start)
    else $error("start did not enter address phase");

  chk_stop_idle: assert property (
    stop_det && !start_det |=> state_q == ST_IDLE ##1 sda_oe_n)
    else $error("stop did not release the serial logic");

  chk_ack_drive: assert property (
    $rose(drv_low_q) && state_q == ST_ADDR_ACK |=> !sda_oe_n && !sda_out)
    else $error("address acknowledge not driven low");

  chk_a0_stable: assert property (
    cap_cnt_q == `DPW_A0_CAPTURE |=> $stable(a0_lat_q))
    else $error("captured address bit changed");

  chk_apb_answer: assert property (
    psel && !penable |=> pready ##1 !pready)
    else $error("apb answer not in first access cycle");

endmodule

// File: design/dpw_cfg.svh
/*
  Constants of the two-wire potentiometer controller: register offsets,
  reset values, fixed address bits and timing figures.
  Assumes it is included by bare name from the design files.
*/
`ifndef DPW_CFG_SVH
`define DPW_CFG_SVH

// ==========================================================================
// register offsets (byte addresses on the register bus)
`define DPW_OFS_WIPER0      8'h00
`define DPW_OFS_TERMINAL_CONNECT_REG        8'h08
`define DPW_OFS_CMD         8'h0c
`define DPW_OFS_STATUS      8'h10

// ==========================================================================
// reset values
`define DPW_TERMINAL_CONNECT_REG_RESET      8'hff
`define DPW_WIPER_MID_8BIT  10'h080
`define DPW_WIPER_MID_7BIT  10'h040

// ==========================================================================
// field positions
`define DPW_TERMINAL_CONNECT_REG_NET_BITS   4
`define DPW_CMD_INC_POS     0
`define DPW_CMD_DEC_POS     1
`define DPW_STAT_A0_POS     0
`define DPW_STAT_BUSY_POS   1
`define DPW_STAT_LAST_LSB   8
`define DPW_STAT_CNT_LSB    16

// ==========================================================================
// serial address and timing
`define DPW_DEV_CODE        4'h5
`define DPW_CLK_HZ          250000000
`define DPW_HS_SCL_HZ       3400000
`define DPW_HS_SCL_CYCLES   (`DPW_CLK_HZ / `DPW_HS_SCL_HZ)
`define DPW_SYNC_LATENCY    3
`define DPW_A0_CAPTURE      2'd3

`endif

// File: design/dpw_pkg.sv
/*
  Types shared by the potentiometer controller files.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package dpw_pkg;

  typedef enum logic [2:0]
  {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_RX,
    ST_RX_ACK,
    ST_TX,
    ST_TX_ACK
  } dpw_i2c_state_type;

  typedef struct packed
  {
    logic network_hw_shutdown_n;
    logic term_a_connect_bit;
    logic wiper_connect_bit;
    logic term_b_connect_bit;
  } dpw_terminal_connect_reg_net_type;

  typedef struct packed
  {
    logic [8:0] tap;
    logic       network_terminal_a;
    logic       network_wiper_terminal;
    logic       network_terminal_b;
    logic       wiper_tied_b;
  } dpw_net_out_type;

endpackage

// File: design/dpw_net_ctrl.sv
/*
  One resistor network: maps the wiper code onto a ladder tap and applies
  the terminal connect and shutdown settings.
  Assumes code and settings come from registers on the same clock.
*/
`timescale 1ns/100ps
`include "dpw_cfg.svh"

module dpw_net_ctrl
  import dpw_pkg::*;
#(
  parameter int RES_BITS = 8
)
(
  // clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // settings
  input  wire logic [9:0]       wiper_code,
  input  wire dpw_terminal_connect_reg_net_type terminal_connect_reg,
  // network state
  output dpw_net_out_type       net_out
);

  localparam logic [9:0] FULL = 10'(1 << RES_BITS);

  dpw_net_out_type net_q;
  dpw_net_out_type net_d;

  // ========================================================================
  // tap and terminal mapping
  always_comb
  begin
    net_d = '0;
    if (wiper_code >= FULL)
    begin
      net_d.tap = FULL[8:0];
    end
    else
    begin
      net_d.tap = wiper_code[8:0];
    end
    if (!terminal_connect_reg.network_hw_shutdown_n)
    begin
      // connect bits are overridden here, never rewritten
      net_d.network_terminal_a     = 1'b0;
      net_d.network_wiper_terminal = 1'b0;
      net_d.network_terminal_b     = 1'b1;
      net_d.wiper_tied_b           = 1'b1;
    end
    else
    begin
      net_d.network_terminal_a     = terminal_connect_reg.term_a_connect_bit;
      net_d.network_wiper_terminal = terminal_connect_reg.wiper_connect_bit;
      net_d.network_terminal_b     = terminal_connect_reg.term_b_connect_bit;
      net_d.wiper_tied_b           = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      net_q <= '0;
    else
      net_q <= net_d;
  end

  assign net_out = net_q;

  // ========================================================================
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_shutdown_state: assert property (
    !terminal_connect_reg.network_hw_shutdown_n |=>
      (!net_q.network_terminal_a && net_q.wiper_tied_b))
    else $error("shutdown did not isolate terminal a");

  chk_resume_control: assert property (
    $rose(terminal_connect_reg.network_hw_shutdown_n) |=>
      (net_q.network_terminal_a == $past(terminal_connect_reg.term_a_connect_bit)
       && !net_q.wiper_tied_b
       && net_q.tap == 9'($past(wiper_code) >= FULL ? FULL
                                                     : $past(wiper_code))))
    else $error("leaving shutdown did not restore state");

  chk_over_full_tap: assert property (
    (wiper_code > FULL) |=> (net_q.tap == FULL[8:0]))
    else $error("code above full scale not mapped to terminal a");

endmodule

// File: verif/dpw_i2c_master.sv
/*
  Two-wire bus master model: makes the serial clock, START, STOP and
  byte transfers for the bench.
  Assumes the bench resolves SDA from both parties, pull-up high.
*/
`timescale 1ns/100ps

module dpw_i2c_master
(
  // clock
  input  wire logic pclk,
  // bus lines
  input  wire logic sda,
  output logic      scl,
  output logic      sda_hi
);
  // ==========================================================
  // bus idle: clock stands high between frames
  initial
  begin
    scl    = 1'b1;
    sda_hi = 1'b1;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // ==========================================================
  // conditions and bits; 16 pclk per serial clock = 64 ns
  task automatic bus_start();
    sda_hi <= 1'b1;
    wait_clk(4);
    scl    <= 1'b1;
    wait_clk(8);
    sda_hi <= 1'b0;
    wait_clk(8);
    scl    <= 1'b0;
    wait_clk(2);
  endtask

  task automatic bus_stop();
    sda_hi <= 1'b0;
    wait_clk(6);
    scl    <= 1'b1;
    wait_clk(8);
    sda_hi <= 1'b1;
    wait_clk(8);
  endtask

  // data moves 2 pclk after the fall so it never races it
  task automatic bit_xfer(input logic b, output logic s);
    sda_hi <= b;
    wait_clk(6);
    scl    <= 1'b1;
    wait_clk(4);
    s = sda;
    wait_clk(4);
    scl    <= 1'b0;
    wait_clk(2);
  endtask

  task automatic byte_xfer(input logic [7:0] tx, input logic ack_in,
                           output logic [7:0] rx, output logic ack_out);
    for (int i = 7; i >= 0; i--)
      bit_xfer(tx[i], rx[i]);
    bit_xfer(ack_in, ack_out);
  endtask
endmodule

// File: verif/dpw_pot_ctrl_tb.sv
/*
  Self-checking bench of the potentiometer controller: APB register
  tests, wiper limits, shutdown and serial slave traffic.
  Assumes the master model drives the serial pins.
*/
`timescale 1ns/100ps

module dpw_pot_ctrl_tb;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        scl;
  logic        sda_hi;
  logic        sda_out;
  logic        sda_oe_n;
  logic        sda_line;
  logic        addr_pin_0 = 1'b1;
  logic        addr_pin_1 = 1'b0;
  logic        addr_pin_2 = 1'b1;
  int          errors = 0;
  int          check_count = 0;
  int          cyc = 0;
  dpw_pkg::dpw_net_out_type [1:0] net_out;
  logic [9:0]  wcode [6] = '{10'h100, 10'h3ff, 10'h3ff, 10'h000,
                             10'h100, 10'h07f};
  logic [1:0]  wcmd [6] = '{2'h1, 2'h1, 2'h2, 2'h2, 2'h2, 2'h1};
  logic [9:0]  wexp [6] = '{10'h100, 10'h3ff, 10'h3ff, 10'h000,
                            10'h0ff, 10'h080};

  // open drain: low if either party pulls
  assign sda_line = sda_hi & (sda_oe_n | sda_out);

  always #2 pclk = ~pclk;

  dpw_pot_ctrl i_dut (
    .pclk       (pclk),
    .presetn    (presetn),
    .psel       (psel),
    .penable    (penable),
    .pwrite     (pwrite),
    .paddr      (paddr),
    .pwdata     (pwdata),
    .prdata     (prdata),
    .pready     (pready),
    .pslverr    (pslverr),
    .scl_in     (scl),
    .sda_in     (sda_line),
    .sda_out    (sda_out),
    .sda_oe_n   (sda_oe_n),
    .addr_pin_0 (addr_pin_0),
    .addr_pin_1 (addr_pin_1),
    .addr_pin_2 (addr_pin_2),
    .net_out    (net_out)
  );

  dpw_i2c_master i_master (
    .pclk   (pclk),
    .sda    (sda_line),
    .scl    (scl),
    .sda_hi (sda_hi)
  );

  // ==========================================================
  // compare, verdict, hang guard
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      errors++;
      results();
    end
  end

  // ==========================================================
  // register bus and serial helpers
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd,
                     output logic e);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= wd;
    penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    e  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic        e;
    apb(1'b0, a, 32'h0, d, e);
    check(d, exp);
  endtask

  task automatic net_chk(input int n, input logic [8:0] tap,
                         input logic [3:0] sw);
    check({19'h0, net_out[n]}, {19'h0, tap, sw});
  endtask

  task automatic sbyte(input logic [7:0] b, input logic exp_ack);
    logic [7:0] r;
    logic       k;
    i_master.byte_xfer(b, 1'b1, r, k);
    check({31'h0, k}, {31'h0, exp_ack});
  endtask

  task automatic srd(input logic ack_in, input logic [7:0] exp);
    logic [7:0] r;
    logic       k;
    i_master.byte_xfer(8'hff, ack_in, r, k);
    check({24'h0, r}, {24'h0, exp});
  endtask

  // ==========================================================
  // main sequence
  initial
  begin
    logic [31:0] d;
    logic        e;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd_chk(8'h00, 32'h80);
    rd_chk(8'h04, 32'h80);
    rd_chk(8'h08, 32'hff);
    rd_chk(8'h10, 32'h01);
    net_chk(0, 9'd128, 4'b1110);
    apb(1'b0, 8'h14, 32'h0, d, e);
    check({31'h0, e}, 32'h1);
    check(d, 32'h0);
    apb(1'b1, 8'h0a, 32'h0, d, e);
    check({31'h0, e}, 32'h1);
    rd_chk(8'h08, 32'hff);
    $display("test reset done");

    for (int i = 0; i < 6; i++)
    begin
      wr(8'h00, {22'h0, wcode[i]});
      wr(8'h0c, {30'h0, wcmd[i]});
      rd_chk(8'h00, {22'h0, wexp[i]});
      net_chk(0, (wexp[i] > 10'h100) ? 9'h100 : wexp[i][8:0],
              4'b1110);
    end
    // both step bits of net 0 cancel; net 1 steps up on its own
    wr(8'h0c, 32'h7);
    rd_chk(8'h00, 32'h80);
    rd_chk(8'h04, 32'h81);
    $display("test wiper limits done");

    // pin 0 changes now; the captured level must stay in use
    addr_pin_0 <= 1'b0;
    i_master.bus_start();
    sbyte(8'h5a, 1'b0);
    sbyte(8'ha5, 1'b0);
    rd_chk(8'h10, 32'h01a503);
    i_master.bus_stop();
    rd_chk(8'h10, 32'h01a501);
    i_master.bus_start();
    sbyte(8'h58, 1'b1);
    sbyte(8'h11, 1'b1);
    i_master.bus_start();
    sbyte(8'hf0, 1'b1);
    i_master.bus_stop();
    rd_chk(8'h10, 32'h01a501);
    i_master.bus_start();
    sbyte(8'h5b, 1'b0);
    srd(1'b0, 8'ha5);
    srd(1'b1, 8'ha5);
    i_master.bus_stop();
    $display("test serial done");

    wr(8'h08, 32'hf7);
    rd_chk(8'h08, 32'hf7);
    net_chk(0, 9'd128, 4'b0011);
    net_chk(1, 9'd129, 4'b1110);
    i_master.bus_start();
    sbyte(8'h5a, 1'b0);
    sbyte(8'h3c, 1'b0);
    i_master.bus_stop();
    rd_chk(8'h10, 32'h023c01);
    wr(8'h08, 32'hfa);
    rd_chk(8'h08, 32'hfa);
    net_chk(0, 9'd128, 4'b0100);
    $display("test shutdown done");

    // second supply fault reset with pin 0 low: it must be caught anew
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd_chk(8'h00, 32'h80);
    rd_chk(8'h04, 32'h80);
    rd_chk(8'h08, 32'hff);
    rd_chk(8'h10, 32'h00);
    net_chk(1, 9'd128, 4'b1110);
    $display("test second reset done");
    results();
  end
endmodule
